// ==== design/ilfm_regs.vh ====
// Behaviour
// - Tx data, tx enable and rx data cross the barrier together, time-shared.
// - Crossing signals are sampled and encoded; 250ns jitter, 600ns delay.
// - Tx enable reaches the driver after about 875ns, within 125ns.
// - Link communication restarts within about 1us to 2us after a fault.
// - Logic side flags a time-out when isolated-side traffic stops.
// - Low supply on either side tri-states the driver and forces the receive output high until recovery; tx data still reaches o_drv_data.
// - Thermal shutdown tri-states the driver and flags a fault.
// - Low slew select gives slow edges; high or open gives fast edges.
// - Fault covers low supply, thermal shutdown and link time-out.
// - During any fault the receive output is forced high.
// - Open or shorted pair raises no fault; receiver outputs read high.
// - Fault pin driven weakly: up for fault, down for healthy.
// - Sampler runs from a nominal 4MHz tick, asynchronous to data.
// - High tx enable enables the driver; low leaves it high impedance.
// - Low rx enable enables the receive output; high tri-states it.
// - Isolated-side receive output is always driven.
`ifndef ILFM_REGS_VH
`define ILFM_REGS_VH
`define ILFM_CLK_MHZ 250
`define ILFM_SAMPLE_NS 250
`define ILFM_SAMPLE_CYC ((`ILFM_SAMPLE_NS * `ILFM_CLK_MHZ) / 1000)
`define ILFM_DATA_DLY_NS 600
`define ILFM_DATA_DLY_CYC ((`ILFM_DATA_DLY_NS * `ILFM_CLK_MHZ) / 1000)
`define ILFM_EN_DLY_NS 875
`define ILFM_EN_TOL_NS 125
// Fixed part only; the tick wait adds up to one sample period on top
`define ILFM_EN_DLY_CYC (((`ILFM_EN_DLY_NS - `ILFM_EN_TOL_NS) * `ILFM_CLK_MHZ) / 1000)
// Sync, tick pick-up and output stages, taken out of each lane's latency
`define ILFM_PIPE_CYC 6
`define ILFM_START_NS 1200
`define ILFM_START_CYC ((`ILFM_START_NS * `ILFM_CLK_MHZ) / 1000)
`define ILFM_TOF_NS 1200
`define ILFM_TOF_CYC ((`ILFM_TOF_NS * `ILFM_CLK_MHZ) / 1000)
`define ILFM_DLY_W 8
`define ILFM_CNT_W 10
`define ILFM_STAT_FAULT_BIT 0
`define ILFM_STAT_W 1
`endif

// ==== design/ilfm_link_monitor.v ====
`include "ilfm_regs.vh"
module ilfm_link_monitor (
    input wire i_clk_sys,
    input wire i_sys_rst,
    input wire i_tx_bit_in,
    input wire i_tx_enable,
    input wire i_rx_out_enable_low,
    input wire i_line_rx,
    input wire i_uv_logic,
    input wire i_uv_iso,
    input wire i_thermal_sd,
    input wire i_iso_link_alive,
    input wire i_slew_select_low,
    input wire [1:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    output reg o_irq,
    output reg o_drv_data,
    output reg o_drv_oe,
    output reg o_drv_slow,
    output reg o_rx_line_output,
    output reg o_rx_line_output_oe,
    output reg o_iso_side_rx_out,
    output reg o_rx_out_enable_low,
    output reg o_rx_out_enable_low_oe
);
    localparam [1:0] ST_START = 2'h0;
    localparam [1:0] ST_RUN = 2'h1;
    localparam [1:0] ST_FAULT = 2'h2;
    localparam [1:0] A_STAT = 2'h0;
    localparam [1:0] A_MASK = 2'h1;
    localparam [1:0] A_LIVE = 2'h2;
    localparam integer SMP_MAX_I = `ILFM_SAMPLE_CYC - 1;
    localparam integer DLY_DATA_I = `ILFM_DATA_DLY_CYC - `ILFM_PIPE_CYC;
    localparam integer DLY_EN_I = `ILFM_EN_DLY_CYC - `ILFM_PIPE_CYC;
    localparam integer START_MAX_I = `ILFM_START_CYC;
    localparam integer TOF_MAX_I = `ILFM_TOF_CYC;
    // Counts fit their counters; cut to width on purpose
    localparam [`ILFM_DLY_W-1:0] SMP_MAX = SMP_MAX_I[`ILFM_DLY_W-1:0];
    localparam [`ILFM_DLY_W-1:0] DLY_DATA = DLY_DATA_I[`ILFM_DLY_W-1:0];
    localparam [`ILFM_DLY_W-1:0] DLY_EN = DLY_EN_I[`ILFM_DLY_W-1:0];
    localparam [`ILFM_CNT_W-1:0] START_MAX = START_MAX_I[`ILFM_CNT_W-1:0];
    localparam [`ILFM_CNT_W-1:0] TOF_MAX = TOF_MAX_I[`ILFM_CNT_W-1:0];

    // Three-stage synchronisers for all pin inputs, one per bit
    wire [8:0] pin_raw;
    wire [8:0] pin_s;
    assign pin_raw = {i_slew_select_low, i_iso_link_alive, i_thermal_sd,
        i_uv_iso, i_uv_logic, i_line_rx, i_rx_out_enable_low,
        i_tx_enable, i_tx_bit_in};
    genvar g;
    generate
        for (g = 0; g < 9; g = g + 1) begin : g_sync
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg v_q;
            always @(posedge i_clk_sys) begin
                if (i_sys_rst) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    v_q <= 1'b0;
                end else begin
                    s1_q <= pin_raw[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        v_q <= s3_q;
                    end
                end
            end
            assign pin_s[g] = v_q;
        end
    endgenerate
    wire di_s = pin_s[0];
    wire de_s = pin_s[1];
    wire re_s = pin_s[2];
    wire line_s = pin_s[3];
    wire uv_s = pin_s[4] | pin_s[5];
    wire tsd_s = pin_s[6];
    wire alive_s = pin_s[7];
    wire slo_s = pin_s[8];

    reg [1:0] state_q;
    reg [`ILFM_DLY_W-1:0] smp_q;
    reg [`ILFM_CNT_W-1:0] cnt_q;
    reg alive_last_q;
    reg [`ILFM_STAT_W-1:0] stat_q;
    reg [`ILFM_STAT_W-1:0] mask_q;
    reg [`ILFM_STAT_W-1:0] live_q;

    // 4MHz sample tick from the system clock
    wire tick = (smp_q == SMP_MAX);
    wire alive_edge = alive_s ^ alive_last_q;
    wire tof = (cnt_q >= TOF_MAX);
    wire supply_bad = uv_s | tsd_s;
    wire fault = supply_bad | (state_q != ST_RUN);
    wire link_ok = (state_q == ST_RUN);

    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            smp_q <= {`ILFM_DLY_W{1'b0}};
            alive_last_q <= 1'b0;
        end else begin
            smp_q <= tick ? {`ILFM_DLY_W{1'b0}} : smp_q + 1'b1;
            alive_last_q <= alive_s;
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_q <= ST_START;
            cnt_q <= {`ILFM_CNT_W{1'b0}};
        end else begin
            case (state_q)
                ST_START: begin
                    // low supply or thermal shutdown holds the link down
                    if (uv_s | tsd_s) begin
                        cnt_q <= {`ILFM_CNT_W{1'b0}};
                    end else if (cnt_q >= START_MAX) begin
                        state_q <= ST_RUN;
                        cnt_q <= {`ILFM_CNT_W{1'b0}};
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_RUN: begin
                    if (uv_s | tsd_s | tof) begin
                        state_q <= ST_FAULT;
                        cnt_q <= {`ILFM_CNT_W{1'b0}};
                    end else if (alive_edge) begin
                        cnt_q <= {`ILFM_CNT_W{1'b0}};
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_FAULT: begin
                    // one cycle here, then back to ST_START for the restart count
                    state_q <= ST_START;
                    cnt_q <= {`ILFM_CNT_W{1'b0}};
                end
                default: begin
                    state_q <= ST_START;
                    cnt_q <= {`ILFM_CNT_W{1'b0}};
                end
            endcase
        end
    end

    // data, enable and rx share one sample frame
    // sampled at tick, then delayed through encoding
    wire [2:0] lane_in;
    wire [2:0] lane_out;
    assign lane_in = {line_s, de_s, di_s};
    genvar k;
    generate
        for (k = 0; k < 3; k = k + 1) begin : g_lane
            // enable path carries the longer latency
            localparam [`ILFM_DLY_W-1:0] LAT = (k == 1) ? DLY_EN : DLY_DATA;
            reg frame_q;
            reg pend_q;
            reg out_q;
            reg [`ILFM_DLY_W-1:0] dly_q;
            wire start_w;
            wire done_w;
            // One change in flight; a later one waits for the first tick after the pending one lands
            assign start_w = tick & ~pend_q & (frame_q != lane_in[k]);
            assign done_w = pend_q & (dly_q >= LAT - 1'b1);
            always @(posedge i_clk_sys) begin
                if (i_sys_rst) begin
                    frame_q <= 1'b1;
                    pend_q <= 1'b0;
                    out_q <= 1'b1;
                    dly_q <= {`ILFM_DLY_W{1'b0}};
                end else begin
                    if (start_w) begin
                        frame_q <= lane_in[k];
                        pend_q <= 1'b1;
                        dly_q <= {`ILFM_DLY_W{1'b0}};
                    end else if (done_w) begin
                        pend_q <= 1'b0;
                        out_q <= frame_q;
                    end else if (pend_q) begin
                        dly_q <= dly_q + 1'b1;
                    end
                end
            end
            assign lane_out[k] = out_q;
        end
    endgenerate

    // Driver side outputs
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_drv_data <= 1'b1;
            o_drv_oe <= 1'b0;
            o_drv_slow <= 1'b0;
        end else begin
            o_drv_data <= lane_out[0];
            o_drv_oe <= lane_out[1] & link_ok & ~supply_bad;
            o_drv_slow <= ~slo_s;
        end
    end

    // Receive side outputs
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_rx_line_output <= 1'b1;
            o_rx_line_output_oe <= 1'b0;
            o_iso_side_rx_out <= 1'b1;
        end else begin
            o_rx_line_output <= fault ? 1'b1 : lane_out[2];
            o_rx_line_output_oe <= ~re_s;
            o_iso_side_rx_out <= line_s;
        end
    end

    // Weak drive stays on; a host driving the pin simply overrides it
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_rx_out_enable_low <= 1'b1;
            o_rx_out_enable_low_oe <= 1'b1;
        end else begin
            o_rx_out_enable_low <= fault;
            o_rx_out_enable_low_oe <= 1'b1;
        end
    end

    // Sticky status; a fault in the clear cycle wins over the clear
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            stat_q <= {`ILFM_STAT_W{1'b0}};
        end else if (i_wr && i_addr == A_STAT) begin
            stat_q <= (stat_q & ~i_wdata[`ILFM_STAT_W-1:0]) |
                {`ILFM_STAT_W{fault}};
        end else begin
            stat_q <= stat_q | {`ILFM_STAT_W{fault}};
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            mask_q <= {`ILFM_STAT_W{1'b0}};
        end else if (i_wr && i_addr == A_MASK) begin
            mask_q <= i_wdata[`ILFM_STAT_W-1:0];
        end
    end

    // Live fault view, read-only
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            live_q <= {`ILFM_STAT_W{1'b0}};
        end else begin
            live_q[`ILFM_STAT_FAULT_BIT] <= fault;
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(stat_q & mask_q);
        end
    end

    // Read data stands one cycle only, zero otherwise
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            case (i_addr)
                A_STAT: o_rdata <= {31'h00000000, stat_q};
                A_MASK: o_rdata <= {31'h00000000, mask_q};
                A_LIVE: o_rdata <= {31'h00000000, live_q};
                default: o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end
endmodule

// ==== bench/ilfm_link_monitor_asserts.sv ====
module ilfm_chk (
    input logic i_clk_sys,
    input logic i_sys_rst,
    input logic i_tx_enable,
    input logic i_rx_out_enable_low,
    input logic i_uv_iso,
    input logic i_thermal_sd,
    input logic i_slew_select_low,
    input logic o_drv_oe,
    input logic o_drv_slow,
    input logic o_rx_line_output,
    input logic o_rx_line_output_oe,
    input logic o_rx_out_enable_low
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    rx_forced_a: assert property (
        o_rx_out_enable_low[*2] |-> o_rx_line_output) else $error("rx low");
    drv_off_a: assert property (
        o_rx_out_enable_low[*2] |-> !o_drv_oe) else $error("drv on in fault");
    thermal_off_a: assert property (
        i_thermal_sd[*8] |-> o_rx_out_enable_low && !o_drv_oe)
        else $error("thermal ignored");
    uv_fault_a: assert property (
        i_uv_iso[*8] |-> o_rx_out_enable_low) else $error("uv ignored");
    rx_hiz_a: assert property (
        i_rx_out_enable_low[*8] |-> !o_rx_line_output_oe)
        else $error("rx not off");
    rx_on_a: assert property (
        (!i_rx_out_enable_low)[*8] |-> o_rx_line_output_oe)
        else $error("rx not on");
    slew_mode_a: assert property (
        $stable(i_slew_select_low)[*8] |-> o_drv_slow == !i_slew_select_low)
        else $error("slew wrong");
    drv_cause_a: assert property (
        $rose(o_drv_oe) |-> $past(i_tx_enable, 180))
        else $error("drv on without enable");
endmodule

// ==== bench/ilfm_host.sv ====
module ilfm_host (
    input logic clk,
    input logic [2:0] cmd,
    input logic pin_fault,
    output logic [2:0] o_pins,
    output logic fault_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_pins = 3'H0;
    always @(posedge clk) o_pins <= cmd;
    always @(posedge clk) fault_seen <= pin_fault;
endmodule

// ==== bench/ilfm_link_monitor_bench.sv ====
`define CHK(s, e, a) begin cmp_count++; if ((a) !== (e)) begin \
    miscompares++; $display("[ERR] %s exp %h got %h", s, e, a); end end
module ilfm_link_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'B0, i_sys_rst = 1'B1, i_tx_bit_in, i_tx_enable;
    logic i_rx_out_enable_low, i_line_rx = 1'B1, i_uv_logic = 1'B0;
    logic i_uv_iso = 1'B0, i_thermal_sd = 1'B0, i_iso_link_alive = 1'B0;
    logic i_slew_select_low = 1'B1, i_wr = 1'B0, i_rd = 1'B0, fault_seen;
    logic [1:0] i_addr = 2'H0;
    logic [2:0] cmd = 3'H0;
    logic [3:0] tk = 4'H0;
    logic [31:0] i_wdata = 32'H0, o_rdata, rdv;
    logic o_irq, o_drv_data, o_drv_oe, o_drv_slow, o_rx_line_output;
    logic o_rx_line_output_oe, o_iso_side_rx_out, o_rx_out_enable_low;
    logic o_rx_out_enable_low_oe, alive_en = 1'B1;
    int miscompares = 0, cmp_count = 0, n;
    ilfm_link_monitor u_ilfm_link_monitor (.*);
    ilfm_host u_ilfm_host (.clk(i_clk_sys), .cmd(cmd),
        .pin_fault(o_rx_out_enable_low), .fault_seen(fault_seen),
        .o_pins({i_rx_out_enable_low, i_tx_bit_in, i_tx_enable}));
    always #2 i_clk_sys = ~i_clk_sys;
    // Slow toggle so the input synchroniser sees every change
    always @(posedge i_clk_sys) begin
        tk <= tk + 4'H1;
        if (alive_en && tk == 4'H0) i_iso_link_alive <= ~i_iso_link_alive;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge i_clk_sys) {i_wr, i_addr, i_wdata} <= {1'B1, a, d};
        @(posedge i_clk_sys) i_wr <= 1'B0;
    endtask
    task automatic rd(input logic [1:0] a);
        @(posedge i_clk_sys) {i_rd, i_addr} <= {1'B1, a};
        @(posedge i_clk_sys) i_rd <= 1'B0;
        #1 rdv = o_rdata;
    endtask
    task automatic wt(input int s, input logic v);
        n = 0;
        while ((s == 0 ? o_rx_out_enable_low : s == 1 ? o_drv_oe :
                o_drv_data) !== v && n < 2000) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic t_start();
        cyc(1);
        `CHK("drv_oe", 1'B0, o_drv_oe)
        `CHK("rx_out", 1'B1, o_rx_line_output)
        `CHK("flt_oe", 1'B1, o_rx_out_enable_low_oe)
        wt(0, 1'B0);
        `CHK("start", 1'B1, n >= 250 && n <= 500)
        cyc(1);
        `CHK("host_ok", 1'B0, fault_seen)
    endtask
    task automatic t_drive();
        @(posedge i_clk_sys) cmd <= 3'H3;
        wt(1, 1'B1);
        `CHK("en_dly", 1'B1, n >= 187 && n <= 251)
        `CHK("drv_data", 1'B1, o_drv_data)
        @(posedge i_clk_sys) cmd <= 3'H1;
        wt(2, 1'B0);
        `CHK("data_dly", 1'B1, n >= 150 && n <= 214)
    endtask
    task automatic t_rx();
        @(posedge i_clk_sys) i_line_rx <= 1'B0;
        cyc(8);
        `CHK("iso_rx", 1'B0, o_iso_side_rx_out)
        cyc(240);
        `CHK("rx_out", 1'B0, o_rx_line_output)
        @(posedge i_clk_sys) cmd <= 3'H5;
        cyc(10);
        `CHK("rx_off", 1'B0, o_rx_line_output_oe)
        `CHK("iso_kept", 1'B0, o_iso_side_rx_out)
        @(posedge i_clk_sys) {cmd, i_line_rx} <= 4'H3;
        cyc(240);
        `CHK("open_pair", 1'B1, o_rx_line_output)
        `CHK("no_fault", 1'B0, o_rx_out_enable_low)
    endtask
    task automatic t_slew();
        for (int v = 0; v < 2; v++) begin
            @(posedge i_clk_sys) i_slew_select_low <= v[0];
            cyc(8);
            `CHK("slow", ~v[0], o_drv_slow)
        end
    endtask
    task automatic t_faults();
        for (int k = 0; k < 4; k++) begin
            wr(2'H1, {31'H0, k[0]});
            wr(2'H3, 32'H0);
            rd(2'H3);
            `CHK("unmapped", 32'H0, rdv)
            @(posedge i_clk_sys) {alive_en, i_thermal_sd, i_uv_iso,
                i_uv_logic} <= {k != 3, 3'H1 << k};
            cyc(k == 3 ? 330 : 12);
            `CHK("fault", 1'B1, o_rx_out_enable_low)
            `CHK("host_flt", 1'B1, fault_seen)
            `CHK("forced", 1'B1, o_rx_line_output)
            `CHK("drv_off", 1'B0, o_drv_oe)
            `CHK("irq", k[0], o_irq)
            rd(2'H2);
            `CHK("live", 32'H1, rdv)
            @(posedge i_clk_sys) {alive_en, i_thermal_sd, i_uv_iso,
                i_uv_logic} <= 4'H8;
            wt(0, 1'B0);
            `CHK("restart", 1'B1, n <= 500)
            rd(2'H0);
            `CHK("sticky", 32'H1, rdv)
            wr(2'H0, 32'H1);
            rd(2'H0);
            `CHK("cleared", 32'H0, rdv)
            `CHK("irq_off", 1'B0, o_irq)
            wt(1, 1'B1);
            `CHK("drv_back", 1'B1, o_drv_oe)
        end
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_clk_sys);
        i_sys_rst <= 1'B0;
        t_start();
        t_drive();
        t_rx();
        t_slew();
        t_faults();
        summarize();
    end
    initial begin
        #100000;
        miscompares++;
        summarize();
    end
endmodule
bind ilfm_link_monitor ilfm_chk u_ilfm_chk (.*);
